// ==== hdl/rfrx_map.svh ====
// register indices, field positions, presets and timing of the receive framer
`ifndef RFRX_MAP_SVH
`define RFRX_MAP_SVH
`define RFRX_IDX_CHIP 6'h00
`define RFRX_IDX_PROTO 6'h01
`define RFRX_IDX_NORESP 6'h07
`define RFRX_IDX_RXWAIT 6'h08
`define RFRX_IDX_TUNE 6'h0A
`define RFRX_IDX_STAT 6'h0C
`define RFRX_IDX_COLHI 6'h0D
`define RFRX_IDX_COLLO 6'h0E
`define RFRX_IDX_RSSI 6'h0F
`define RFRX_IDX_LEVEL 6'h1E
`define RFRX_IDX_FIFO 6'h1F
`define RFRX_CHIP_AGC 2
`define RFRX_CHIP_SWAP 3
`define RFRX_TUNE_AGCON 0
`define RFRX_TUNE_AGCLVL 1
`define RFRX_ST_NORESP 0
`define RFRX_ST_COLL 1
`define RFRX_ST_FORMAT 2
`define RFRX_ST_CRC 3
`define RFRX_ST_PARITY 4
`define RFRX_ST_THRESH 5
`define RFRX_ST_RXEND 6
`define RFRX_ST_SOF 7
`define RFRX_RST_CHIP 8'h00
`define RFRX_RST_PROTO 8'h08
`define RFRX_PROTO_A 8'h08
`define RFRX_PRE_TUNE_A 8'h40
`define RFRX_PRE_TUNE_X 8'h00
`define RFRX_PRE_RXW_A 8'h0E
`define RFRX_PRE_RXW_X 8'h1F
`define RFRX_PRE_NR 8'h0E
`define RFRX_FIFO_DEPTH 12
`define RFRX_FIFO_THR 9
`define RFRX_AGC_EDGES 16
`define RFRX_CLK_MHZ 100.0
`define RFRX_RXW_STEP_US 9.44
`define RFRX_NR_STEP_US 37.76
`define RFRX_ETU_US 9.44
`define RFRX_CRC_INIT 16'h6363
`define RFRX_CRC_POLY 16'h8408
`endif

// ==== hdl/rfrx_pkg.sv ====
// types shared by the receive framer
package rfrx_pkg;
  typedef logic [7:0] rfrx_byte_t;
  typedef logic [2:0] rfrx_rssi_t;
  typedef enum logic [2:0] {
    RFRX_HUNT  = 3'b001,
    RFRX_BITS  = 3'b010,
    RFRX_CLOSE = 3'b100
  } rfrx_state_e;
endpackage

// ==== hdl/rfrx_framer.sv ====
// receive path control, bit decoder and framer with apb registers
`timescale 1ns/10ps
`include "rfrx_map.svh"
module rfrx_framer (
  // apb
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic [7:0]              paddr,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  // digitized receivers and levels
  input  wire logic                    antenna_input_one,
  input  wire logic                    antenna_input_two,
  input  wire logic                    level_high,
  input  wire rfrx_pkg::rfrx_rssi_t    rssi_one_level,
  input  wire rfrx_pkg::rfrx_rssi_t    rssi_two_level,
  // transmitter events
  input  wire logic                    tx_end,
  input  wire logic                    slot_start,
  // analog controls and host line
  output logic                         rx_swap,
  output logic      [3:0]              filter_select,
  output logic      [1:0]              gain_cut,
  output logic                         agc_level_low,
  output logic                         agc_gain_reduce,
  output logic                         decoder_reset,
  output logic                         irq
);
  import rfrx_pkg::*;

  localparam int RXW_CYC  = int'(`RFRX_RXW_STEP_US * `RFRX_CLK_MHZ);
  localparam int NR_CYC   = int'(`RFRX_NR_STEP_US * `RFRX_CLK_MHZ);
  localparam int HALF_CYC = int'(`RFRX_ETU_US * `RFRX_CLK_MHZ / 2.0);

  logic [7:0]  chip, proto, nr_reg, rxw_reg, tune, stat, st_set, rd_mux, d0, d1;
  logic [9:0]  colpos, half_cnt, bitpos;
  rfrx_rssi_t  rssi_main, rssi_aux;
  logic [8:0]  sync1, sync2, shreg;
  logic        main_d, main_sc, main_edge, hit, wr, rd, proto_a;
  logic [5:0]  idx;
  logic [17:0] rxw_cnt;
  logic [19:0] nr_cnt;
  rfrx_state_e st;
  logic        phase, h1, h2, first, col_seen;
  logic [3:0]  bcnt, wp, rp, cnt;
  logic [1:0]  nbytes;
  logic [15:0] crc;
  logic [4:0]  edge_cnt;
  logic        sof, bit_end, bit_stb, bit_val, byte_done, push, pop, thr_armed, agc_frozen;
  rfrx_byte_t  mem [`RFRX_FIFO_DEPTH];

  function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `RFRX_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // apb slave: read data captured in setup, so the access phase never waits
  assign idx     = paddr[7:2];
  assign pready  = 1'b1;
  assign wr      = psel & penable & pwrite & hit;
  assign rd      = psel & penable & ~pwrite & hit;
  assign pslverr = psel & penable & ~hit;
  assign pop     = rd & (idx == `RFRX_IDX_FIFO) & (cnt != 4'h0);
  assign proto_a = (proto == `RFRX_PROTO_A);

  always_comb begin
    hit    = 1'b1;
    rd_mux = 8'h00;
    unique case (idx)
      `RFRX_IDX_CHIP:   rd_mux = chip;
      `RFRX_IDX_PROTO:  rd_mux = proto;
      `RFRX_IDX_NORESP: rd_mux = nr_reg;
      `RFRX_IDX_RXWAIT: rd_mux = rxw_reg;
      `RFRX_IDX_TUNE:   rd_mux = tune;
      `RFRX_IDX_STAT:   rd_mux = stat;
      `RFRX_IDX_COLHI:  rd_mux = {colpos[9:8], 6'h00};
      `RFRX_IDX_COLLO:  rd_mux = colpos[7:0];
      `RFRX_IDX_RSSI:   rd_mux = {2'h0, rssi_aux, rssi_main};
      `RFRX_IDX_LEVEL:  rd_mux = {4'h0, cnt};
      `RFRX_IDX_FIFO:   rd_mux = (cnt != 4'h0) ? mem[rp] : 8'h00;
      default:          hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= {24'h00_0000, rd_mux};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chip  <= `RFRX_RST_CHIP;
      proto <= `RFRX_RST_PROTO;
    end else if (wr && idx == `RFRX_IDX_CHIP) begin
      chip <= pwdata[7:0];
    end else if (wr && idx == `RFRX_IDX_PROTO) begin
      proto <= pwdata[7:0];
    end
  end

  // a later host write still overrides the presets, so tuning follows selection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tune    <= `RFRX_PRE_TUNE_A;
      rxw_reg <= `RFRX_PRE_RXW_A;
      nr_reg  <= `RFRX_PRE_NR;
    end else if (wr && idx == `RFRX_IDX_PROTO) begin
      tune    <= (pwdata[7:0] == `RFRX_PROTO_A) ? `RFRX_PRE_TUNE_A : `RFRX_PRE_TUNE_X;
      rxw_reg <= (pwdata[7:0] == `RFRX_PROTO_A) ? `RFRX_PRE_RXW_A : `RFRX_PRE_RXW_X;
      nr_reg  <= `RFRX_PRE_NR;
    end else if (wr) begin
      if (idx == `RFRX_IDX_TUNE) tune <= pwdata[7:0];
      if (idx == `RFRX_IDX_RXWAIT) rxw_reg <= pwdata[7:0];
      if (idx == `RFRX_IDX_NORESP) nr_reg <= pwdata[7:0];
    end
  end

  // analog controls straight from the tuning and chip registers
  assign rx_swap       = chip[`RFRX_CHIP_SWAP];
  assign filter_select = tune[7:4];
  assign gain_cut      = tune[3:2];
  assign agc_level_low = tune[`RFRX_TUNE_AGCLVL];

  // pin synchronisers; first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1  <= 9'h000;
      sync2  <= 9'h000;
      main_d <= 1'b0;
    end else begin
      sync1  <= {rssi_two_level, rssi_one_level, level_high, antenna_input_two, antenna_input_one};
      sync2  <= sync1;
      main_d <= main_sc;
    end
  end

  assign main_sc   = rx_swap ? sync2[1] : sync2[0];
  assign main_edge = main_sc & ~main_d;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rssi_main <= 3'h0;
      rssi_aux  <= 3'h0;
    end else if (tx_end) begin
      rssi_main <= 3'h0;
      rssi_aux  <= 3'h0;
    end else begin
      if ((rx_swap ? sync2[8:6] : sync2[5:3]) > rssi_main) rssi_main <= rx_swap ? sync2[8:6] : sync2[5:3];
      if ((rx_swap ? sync2[5:3] : sync2[8:6]) > rssi_aux) rssi_aux <= rx_swap ? sync2[5:3] : sync2[8:6];
    end
  end

  // blanking after transmit; decoder sits in reset while it runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxw_cnt <= 18'h0_0000;
    end else if (tx_end) begin
      rxw_cnt <= 18'(32'(rxw_reg) * RXW_CYC);
    end else if (rxw_cnt != 18'h0_0000) begin
      rxw_cnt <= rxw_cnt - 18'h0_0001;
    end
  end
  assign decoder_reset = (rxw_cnt != 18'h0_0000);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nr_cnt <= 20'h0_0000;
    end else if (slot_start) begin
      nr_cnt <= 20'(32'(nr_reg) * NR_CYC);
    end else if (sof) begin
      nr_cnt <= 20'h0_0000;
    end else if (nr_cnt != 20'h0_0000) begin
      nr_cnt <= nr_cnt - 20'h0_0001;
    end
  end

  // manchester decoder: activity per half bit; 10=one, 01=zero, 11=collision, 00=end
  assign sof     = (st == RFRX_HUNT) & main_edge & ~decoder_reset;
  assign bit_end = (st == RFRX_BITS) & phase & (half_cnt == 10'(HALF_CYC - 1));
  assign bit_stb = bit_end & ~first & (h1 | h2);
  assign bit_val = h1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st       <= RFRX_HUNT;
      half_cnt <= 10'h000;
      phase    <= 1'b0;
      h1       <= 1'b0;
      h2       <= 1'b0;
      first    <= 1'b0;
    end else if (decoder_reset) begin
      st <= RFRX_HUNT;
    end else begin
      unique case (st)
        RFRX_HUNT: begin
          if (main_edge) begin
            st       <= RFRX_BITS;
            half_cnt <= 10'h000;
            phase    <= 1'b0;
            h1       <= 1'b1;
            h2       <= 1'b0;
            first    <= 1'b1;
          end
        end
        RFRX_BITS: begin
          if (half_cnt == 10'(HALF_CYC - 1)) begin
            half_cnt <= 10'h000;
            phase    <= ~phase;
            if (phase) begin
              h1    <= 1'b0;
              h2    <= 1'b0;
              first <= 1'b0;
              if (!first && !h1 && !h2) st <= RFRX_CLOSE;
            end
          end else begin
            half_cnt <= half_cnt + 10'h001;
            if (main_edge && !phase) h1 <= 1'b1;
            if (main_edge && phase) h2 <= 1'b1;
          end
        end
        RFRX_CLOSE: st <= RFRX_HUNT;
      endcase
    end
  end

  // byte assembly, parity and crc; payload lags two bytes so crc never reaches the fifo
  assign byte_done = bit_stb & (bcnt == 4'h8);
  assign push      = byte_done & (nbytes == 2'h2) & (cnt != 4'(`RFRX_FIFO_DEPTH));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shreg    <= 9'h000;
      bcnt     <= 4'h0;
      bitpos   <= 10'h000;
      col_seen <= 1'b0;
      colpos   <= 10'h000;
      d0       <= 8'h00;
      d1       <= 8'h00;
      nbytes   <= 2'h0;
      crc      <= `RFRX_CRC_INIT;
    end else if (sof) begin
      bcnt     <= 4'h0;
      bitpos   <= 10'h000;
      col_seen <= 1'b0;
      nbytes   <= 2'h0;
      crc      <= `RFRX_CRC_INIT;
    end else if (bit_stb) begin
      shreg <= {bit_val, shreg[8:1]};
      if (bcnt != 4'h8) bitpos <= bitpos + 10'h001;
      if (h1 && h2 && proto_a && !col_seen) begin
        col_seen <= 1'b1;
        colpos   <= bitpos;
      end
      if (bcnt == 4'h8) begin
        bcnt   <= 4'h0;
        d0     <= shreg[8:1];
        d1     <= d0;
        crc    <= crc_upd(crc, shreg[8:1]);
        nbytes <= (nbytes == 2'h2) ? 2'h2 : nbytes + 2'h1;
      end else begin
        bcnt <= bcnt + 4'h1;
      end
    end
  end

  // fifo of payload bytes
  always_ff @(posedge pclk) begin
    if (push) mem[wp] <= d1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp  <= 4'h0;
      rp  <= 4'h0;
      cnt <= 4'h0;
    end else begin
      if (push) wp <= (wp == 4'(`RFRX_FIFO_DEPTH - 1)) ? 4'h0 : wp + 4'h1;
      if (pop) rp <= (rp == 4'(`RFRX_FIFO_DEPTH - 1)) ? 4'h0 : rp + 4'h1;
      cnt <= cnt + 4'(push) - 4'(pop);
    end
  end

  // threshold re-arms only once the host drains below nine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thr_armed <= 1'b1;
    end else if (cnt == 4'(`RFRX_FIFO_THR) && thr_armed) begin
      thr_armed <= 1'b0;
    end else if (cnt < 4'(`RFRX_FIFO_THR)) begin
      thr_armed <= 1'b1;
    end
  end

  // event flags
  always_comb begin
    st_set                  = 8'h00;
    st_set[`RFRX_ST_SOF]    = sof;
    st_set[`RFRX_ST_NORESP] = (nr_cnt == 20'h0_0001) & ~sof & ~slot_start;
    st_set[`RFRX_ST_COLL]   = bit_stb & h1 & h2 & proto_a & ~col_seen;
    st_set[`RFRX_ST_PARITY] = byte_done & ~(^shreg[8:1] ^ bit_val);
    st_set[`RFRX_ST_THRESH] = (cnt == 4'(`RFRX_FIFO_THR)) & thr_armed;
    st_set[`RFRX_ST_RXEND]  = (st == RFRX_CLOSE);
    st_set[`RFRX_ST_FORMAT] = (st == RFRX_CLOSE) & ((bcnt != 4'h0) | (nbytes != 2'h2))
                              | (byte_done & (nbytes == 2'h2) & ~push);
    st_set[`RFRX_ST_CRC]    = (st == RFRX_CLOSE) & (nbytes == 2'h2) & (crc != 16'h0000);
  end

  // a read clears only the flags it reported, so events after its setup cycle survive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat <= 8'h00;
    end else if (rd && idx == `RFRX_IDX_STAT) begin
      stat <= (stat & ~prdata[7:0]) | st_set;
    end else begin
      stat <= stat | st_set;
    end
  end
  assign irq = |stat[6:0];

  // agc reduction is one-way and restarts with every frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_cnt <= 5'h00;
    end else if (sof) begin
      edge_cnt <= 5'h01;
    end else if (st == RFRX_BITS && main_edge && !agc_frozen) begin
      edge_cnt <= edge_cnt + 5'h01;
    end
  end
  assign agc_frozen = (edge_cnt >= 5'(`RFRX_AGC_EDGES)) & ~tune[`RFRX_TUNE_AGCON];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      agc_gain_reduce <= 1'b0;
    end else if (sof) begin
      agc_gain_reduce <= 1'b0;
    end else if (chip[`RFRX_CHIP_AGC] && sync2[2] && !agc_frozen) begin
      agc_gain_reduce <= 1'b1;
    end
  end

  swap_route_a: assert property (@(posedge pclk) disable iff (!presetn) $past(presetn, 2) |->
    main_sc == (rx_swap ? $past(antenna_input_two, 2) : $past(antenna_input_one, 2))) else $error("routing wrong");
  agc_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    !chip[`RFRX_CHIP_AGC] && !agc_gain_reduce |=> !agc_gain_reduce) else $error("agc acted while off");
  agc_freeze_a: assert property (@(posedge pclk) disable iff (!presetn)
    agc_frozen && !sof |=> $stable(agc_gain_reduce)) else $error("agc moved after freeze");
  preset_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && idx == `RFRX_IDX_PROTO |=> nr_reg == `RFRX_PRE_NR) else $error("preset not reloaded");
  blank_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    tx_end && rxw_reg != 8'h00 |=> decoder_reset [*8]) else $error("decoder not held after transmit");
  fifo_cap_a: assert property (@(posedge pclk) disable iff (!presetn)
    cnt <= 4'(`RFRX_FIFO_DEPTH)) else $error("fifo count beyond capacity");
  col_pos_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_set[`RFRX_ST_COLL] |=> colpos == $past(bitpos) && stat[`RFRX_ST_COLL]) else $error("collision position lost");
  thr_once_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_set[`RFRX_ST_THRESH] |=> !st_set[`RFRX_ST_THRESH]) else $error("threshold repeated");
  rx_end_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
    st == RFRX_CLOSE |=> irq && stat[`RFRX_ST_RXEND]) else $error("end of reception without irq");
  rssi_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    tx_end |=> rssi_main == 3'h0 && rssi_aux == 3'h0) else $error("rssi not cleared");
  noresp_a: assert property (@(posedge pclk) disable iff (!presetn)
    nr_cnt == 20'h0_0001 && !sof && !slot_start |=> stat[`RFRX_ST_NORESP]) else $error("no-response flag missing");

endmodule // rfrx_framer

// ==== verification/rfrx_tag_model.sv ====
// tag side model: manchester frames on the digitized subcarrier line
`timescale 1ns/10ps
module rfrx_tag_model (
  // clock
  input  wire logic pclk,
  // digitized subcarrier towards the receiver
  output logic      sub_line
);
  import rfrx_pkg::*;
  localparam int HALF = 472;
  initial sub_line = 1'b0;
  // one half bit: four subcarrier pulses from offset off, or silence
  task automatic half(input logic act, input int off);
    for (int i = 0; i < HALF; i++) begin
      sub_line <= act && i >= off && i < off + 256 && ((i - off) % 64) < 32;
      @(posedge pclk);
    end
  endtask
  // data bursts sit mid-half so the sync delay never moves an edge across a half boundary
  task automatic bit_out(input logic b);
    half(b, 150);
    half(!b, 150);
  endtask
  // start bit, bytes lsb first with odd parity, then silence as end; line stays low after
  task automatic send_frame(input rfrx_byte_t data[$], input logic bad_par, input int col_at);
    half(1'b1, 0);
    half(1'b0, 0);
    foreach (data[k]) begin
      for (int j = 0; j < 8; j++) begin
        if (k == 0 && j == col_at) begin
          // two tags answering at once: subcarrier in both halves
          half(1'b1, 150);
          half(1'b1, 150);
        end else begin
          bit_out(data[k][j]);
        end
      end
      bit_out(~^data[k] ^ (bad_par && k == 0));
    end
    repeat (3) half(1'b0, 0);
  endtask
endmodule // rfrx_tag_model

// ==== verification/rfrx_framer_tb_top.sv ====
// self-checking testbench of the receive framer
`timescale 1ns/10ps
`include "rfrx_map.svh"
`define chk(got, exp) begin samples_checked++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("[ERR] %0t got %h expected %h", $time, (got), (exp)); end end
module rfrx_framer_tb_top;
  import rfrx_pkg::*;
  typedef struct { logic [31:0] data; logic [31:0] mask; logic err; } rfrx_note_s;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, v;
  logic [31:0] pwdata, prdata;
  logic        level_high, tx_end, slot_start, tag_on_two, tag_line;
  logic        antenna_input_one, antenna_input_two;
  rfrx_rssi_t  rssi_one_level, rssi_two_level, ra, rb;
  logic        rx_swap, agc_level_low, agc_gain_reduce, decoder_reset, irq;
  logic [3:0]  filter_select;
  logic [1:0]  gain_cut;
  int          n_mismatch, samples_checked, cyc, n;
  integer      seed = 32'h68e1;
  rfrx_note_s  notes[$];
  rfrx_note_s  note;
  rfrx_byte_t  frame[$];
  // the silent input stays low, as a comparator with no subcarrier does
  assign antenna_input_one = tag_on_two ? 1'b0 : tag_line;
  assign antenna_input_two = tag_on_two ? tag_line : 1'b0;
  rfrx_framer rfrx_framer_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .antenna_input_one(antenna_input_one), .antenna_input_two(antenna_input_two), .level_high(level_high),
    .rssi_one_level(rssi_one_level), .rssi_two_level(rssi_two_level), .tx_end(tx_end), .slot_start(slot_start),
    .rx_swap(rx_swap), .filter_select(filter_select), .gain_cut(gain_cut), .agc_level_low(agc_level_low),
    .agc_gain_reduce(agc_gain_reduce), .decoder_reset(decoder_reset), .irq(irq));
  rfrx_tag_model rfrx_tag_model_inst (.pclk(pclk), .sub_line(tag_line));
  always #5 pclk = ~pclk;
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // hang guard: four frames and two timers take about 85000 cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 97000) begin
      n_mismatch++;
      $display("[ERR] %0t timeout", $time);
      conclude();
    end
  end
  // read results are compared at the completing edge against the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      if (notes.size() == 0) begin
        n_mismatch++;
        $display("[ERR] %0t read without note", $time);
      end else begin
        note = notes.pop_front();
        `chk(prdata & note.mask, note.data & note.mask)
        `chk(pslverr, note.err)
      end
    end
  end
  task automatic apb(input logic [5:0] idx, input logic wr, input logic [7:0] wd);
    logic [31:0] r;
    r = $random(seed);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {r[31:8], wd};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] idx, input logic [7:0] exp, input logic [7:0] mask, input logic err);
    notes.push_back('{data: {24'h000000, exp}, mask: {24'hFFFFFF, mask}, err: err});
    apb(idx, 1'b0, 8'h00);
  endtask
  function automatic logic [15:0] crc_a(input logic [7:0] b);
    logic [15:0] c;
    c = `RFRX_CRC_INIT;
    for (int i = 0; i < 8; i++) c = (c >> 1) ^ ((c[0] ^ b[i]) ? `RFRX_CRC_POLY : 16'h0000);
    return c;
  endfunction
  task automatic frame_one(input logic [7:0] b, input logic bad, input logic with_crc, input int col_at = -1);
    logic [15:0] c;
    c = crc_a(b);
    frame.delete();
    frame.push_back(b);
    if (with_crc) begin
      frame.push_back(c[7:0]);
      frame.push_back(c[15:8]);
    end
    rfrx_tag_model_inst.send_frame(frame, bad, col_at);
    repeat (20) @(posedge pclk);
  endtask
  // counts how long the decoders stay blanked after the end of a transmission
  task automatic pulse_tx;
    @(posedge pclk);
    tx_end <= 1'b1;
    @(posedge pclk);
    tx_end <= 1'b0;
    #1;
    n = 0;
    while (decoder_reset === 1'b1 && n < 20000) begin
      @(posedge pclk);
      #1;
      n++;
    end
  endtask
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    level_high = 0; tx_end = 0; slot_start = 0; tag_on_two = 0;
    rssi_one_level = 0; rssi_two_level = 0;
    n_mismatch = 0; samples_checked = 0; cyc = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    `chk(rx_swap, 1'b0)
    `chk(filter_select, 4'h4)
    rd(`RFRX_IDX_CHIP, 8'h00, 8'hFF, 1'b0);
    rd(`RFRX_IDX_PROTO, 8'h08, 8'hFF, 1'b0);
    rd(6'h02, 8'h00, 8'hFF, 1'b1);
    apb(`RFRX_IDX_PROTO, 1'b1, 8'h00);
    rd(`RFRX_IDX_TUNE, 8'h00, 8'hFF, 1'b0);
    rd(`RFRX_IDX_RXWAIT, 8'h1F, 8'hFF, 1'b0);
    rd(`RFRX_IDX_NORESP, 8'h0E, 8'hFF, 1'b0);
    apb(`RFRX_IDX_PROTO, 1'b1, 8'h08);
    rd(`RFRX_IDX_TUNE, 8'h40, 8'hFF, 1'b0);
    rd(`RFRX_IDX_RXWAIT, 8'h0E, 8'hFF, 1'b0);
    $display("test presets done");
    repeat (4) begin
      v = $random(seed);
      apb(`RFRX_IDX_TUNE, 1'b1, v);
      #1;
      `chk(filter_select, v[7:4])
      `chk(gain_cut, v[3:2])
      `chk(agc_level_low, v[1])
      rd(`RFRX_IDX_TUNE, v, 8'hFF, 1'b0);
    end
    $display("test tuning done");
    level_high <= 1'b1;
    repeat (6) @(posedge pclk);
    `chk(agc_gain_reduce, 1'b0)
    apb(`RFRX_IDX_CHIP, 1'b1, 8'h0C);
    repeat (6) @(posedge pclk);
    `chk(agc_gain_reduce, 1'b1)
    `chk(rx_swap, 1'b1)
    level_high <= 1'b0;
    tag_on_two <= 1'b1;
    v = $random(seed);
    frame_one(v, 1'b0, 1'b1);
    `chk(irq, 1'b1)
    `chk(agc_gain_reduce, 1'b0)
    rd(`RFRX_IDX_STAT, 8'hC0, 8'hFF, 1'b0);
    rd(`RFRX_IDX_LEVEL, 8'h01, 8'hFF, 1'b0);
    rd(`RFRX_IDX_FIFO, v, 8'hFF, 1'b0);
    rd(`RFRX_IDX_LEVEL, 8'h00, 8'hFF, 1'b0);
    #1;
    `chk(irq, 1'b0)
    $display("test swapped frame done");
    tag_on_two <= 1'b0;
    frame_one(v, 1'b0, 1'b0);
    rd(`RFRX_IDX_STAT, 8'h00, 8'hFF, 1'b0);
    rd(`RFRX_IDX_LEVEL, 8'h00, 8'hFF, 1'b0);
    $display("test auxiliary input done");
    apb(`RFRX_IDX_CHIP, 1'b1, 8'h00);
    frame_one(v, 1'b1, 1'b1);
    `chk(irq, 1'b1)
    rd(`RFRX_IDX_STAT, 8'h90, 8'h90, 1'b0);
    $display("test parity error done");
    n = $random(seed) & 7;
    v = $random(seed) | (8'h01 << n);
    frame_one(v, 1'b0, 1'b0, n);
    rd(`RFRX_IDX_STAT, 8'hC6, 8'hFF, 1'b0);
    rd(`RFRX_IDX_COLLO, 8'(n), 8'hFF, 1'b0);
    rd(`RFRX_IDX_COLHI, 8'h00, 8'hFF, 1'b0);
    $display("test collision done");
    apb(`RFRX_IDX_RXWAIT, 1'b1, 8'h01);
    pulse_tx();
    `chk(n, 944)
    ra = $random(seed);
    rb = $random(seed);
    rssi_one_level <= ra;
    rssi_two_level <= rb;
    repeat (6) @(posedge pclk);
    rd(`RFRX_IDX_RSSI, {2'b00, rb, ra}, 8'hFF, 1'b0);
    rssi_one_level <= 3'h0;
    rssi_two_level <= 3'h0;
    repeat (6) @(posedge pclk);
    pulse_tx();
    rd(`RFRX_IDX_RSSI, 8'h00, 8'hFF, 1'b0);
    $display("test blanking and rssi done");
    apb(`RFRX_IDX_NORESP, 1'b1, 8'h01);
    @(posedge pclk);
    slot_start <= 1'b1;
    @(posedge pclk);
    slot_start <= 1'b0;
    #1;
    n = 0;
    while (irq !== 1'b1 && n < 10000) begin
      @(posedge pclk);
      #1;
      n++;
    end
    `chk(n >= 3776 && n <= 3777, 1'b1)
    rd(`RFRX_IDX_STAT, 8'h01, 8'h01, 1'b0);
    $display("test no response done");
    repeat (4) @(posedge pclk);
    conclude();
  end
endmodule // rfrx_framer_tb_top
